// >>> hdl/pwmt_pkg.sv
// Constants for the eight-bit PWM timer channel
package pwmt_pkg;
    localparam int PWMT_AW = 8;
    localparam int PWMT_DW = 8;
    // Register offsets
    localparam logic [7:0] PWMT_OFS_MODE = 8'h00;
    localparam logic [7:0] PWMT_OFS_PERIOD = 8'h04;
    localparam logic [7:0] PWMT_OFS_DUTY = 8'h08;
    localparam logic [7:0] PWMT_OFS_STATUS = 8'h0C;
    localparam logic [7:0] PWMT_OFS_MASK = 8'h10;
    localparam logic [7:0] PWMT_OFS_COUNT = 8'h14;
    // Mode register field positions
    localparam int PWMT_MODE_RUN = 0;
    localparam int PWMT_MODE_LEVEL = 1;
    localparam int PWMT_MODE_OE = 2;
    localparam int PWMT_MODE_CKS_LO = 4;
    localparam int PWMT_MODE_CKS_W = 3;
    // Status and mask bit positions
    localparam int PWMT_ST_PERIOD = 0;
    // Values after reset
    localparam logic [7:0] PWMT_RST_MODE = 8'h00;
    localparam logic [7:0] PWMT_RST_PERIOD = 8'hFF;
    localparam logic [7:0] PWMT_RST_DUTY = 8'h00;
    localparam logic [7:0] PWMT_RST_MASK = 8'h00;
    // Count clocks from a duty write to its use
    localparam logic [1:0] PWMT_DUTY_DELAY = 2'h3;
endpackage : pwmt_pkg

// >>> hdl/pwmt_top.sv
// Eight-bit PWM timer channel with register port and period interrupt
//
// Functional notes
// RULE1: Output inactive until first period match follows.
// RULE2: Software leaves period alone while counting.
// RULE3: Software keeps duty below period, eight bits.
// RULE4: Run bit set starts PWM counting.
// RULE5: Run bit cleared stops counting.
// RULE6: Output enable zero drives pin low.
// RULE7: Software port latch may hold pin high.
// RULE8: Start level from select; toggle on match.
// RULE9: Pin reaches pad only with port bits zero.
// RULE10: Period is count clock times period+1.
// RULE11: Active width is count clock times duty+1.
// RULE12: Interrupt on count clock after period match.
// RULE13: Duty write applies after three count clocks.
// RULE14: Counter clears after match and keeps counting.
`timescale 1ns/1ps
module pwmt_top
    import pwmt_pkg::*;
(
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register port
    input wire logic [PWMT_AW-1:0] reg_addr,
    input wire logic [PWMT_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [PWMT_DW-1:0] reg_rdata,
    // Timer output and interrupt
    output logic pwm_output_pin,
    output logic period_interrupt
);

    // Register map, byte offsets from the package:
    //   MODE   run, level select, output enable, count clock select
    //   PERIOD period compare, written at any time and taken at once
    //   DUTY   duty compare, reaches the compare after three count clocks while running, at once when stopped
    //   STATUS sticky period event, cleared by a read
    //   MASK   one blocks the interrupt output
    //   COUNT  up-counter, read only
    // Count clock is sys_clk divided by two to the power of the select field.

    typedef struct packed {
        // Mode register fields
        logic timer_run_bit;
        logic active_level_select;
        logic output_enable_bit;
        logic [PWMT_MODE_CKS_W-1:0] clock_select_field;
        // Compare values and delayed duty transfer
        logic [7:0] period_compare;
        logic [7:0] duty_compare;
        logic [7:0] duty_compare_alias;
        logic [1:0] duty_wait;
        // Count clock divider and up-counter
        logic [7:0] prescale;
        logic [7:0] count;
        // Waveform, event and read path
        logic active;
        logic status;
        logic mask;
        logic pin;
        logic [PWMT_DW-1:0] rdata;
    } pwmt_state_t;

    pwmt_state_t st;
    pwmt_state_t next_st;
    logic [7:0] div_mask;
    logic tick;

    always_comb begin
        div_mask = 8'((9'h001 << st.clock_select_field) - 9'h001);
        tick = st.timer_run_bit && ((st.prescale & div_mask) == div_mask);
    end

    always_comb begin
        next_st = st;
        if (st.timer_run_bit) begin
            next_st.prescale = st.prescale + 8'h01;
        end else begin
            next_st.prescale = 8'h00;
        end
        // Counting
        if (!st.timer_run_bit) begin
            next_st.count = 8'h00; // RULE5
            next_st.active = 1'b0; // RULE1
        end else if (tick) begin
            if (st.count == st.period_compare) begin
                next_st.count = 8'h00; // RULE14 RULE10
                next_st.active = ~st.active; // RULE8 RULE1
                next_st.status = 1'b1; // RULE12
            end else begin
                next_st.count = st.count + 8'h01;
                if (st.active && st.count == st.duty_compare_alias) begin
                    next_st.active = 1'b0; // RULE11
                end
            end
        end
        // Delayed transfer of the duty value
        if (tick && st.duty_wait != 2'h0) begin
            next_st.duty_wait = st.duty_wait - 2'h1;
            if (st.duty_wait == 2'h1) begin
                next_st.duty_compare_alias = st.duty_compare; // RULE13
            end
        end
        // Register reads
        next_st.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                PWMT_OFS_MODE: begin
                    next_st.rdata[PWMT_MODE_RUN] = st.timer_run_bit;
                    next_st.rdata[PWMT_MODE_LEVEL] = st.active_level_select;
                    next_st.rdata[PWMT_MODE_OE] = st.output_enable_bit;
                    next_st.rdata[PWMT_MODE_CKS_LO +: PWMT_MODE_CKS_W] = st.clock_select_field;
                end
                PWMT_OFS_PERIOD: begin
                    next_st.rdata = st.period_compare;
                end
                PWMT_OFS_DUTY: begin
                    // Software sees the last written value, not the delayed copy
                    next_st.rdata = st.duty_compare;
                end
                PWMT_OFS_STATUS: begin
                    next_st.rdata[PWMT_ST_PERIOD] = st.status;
                    // A period event in the same cycle wins over the clear
                    if (!(tick && st.count == st.period_compare)) begin
                        next_st.status = 1'b0;
                    end
                end
                PWMT_OFS_MASK: begin
                    next_st.rdata[PWMT_ST_PERIOD] = st.mask;
                end
                PWMT_OFS_COUNT: begin
                    next_st.rdata = st.count;
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end
        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                PWMT_OFS_MODE: begin
                    next_st.timer_run_bit = reg_wdata[PWMT_MODE_RUN]; // RULE4 RULE5
                    next_st.active_level_select = reg_wdata[PWMT_MODE_LEVEL];
                    next_st.output_enable_bit = reg_wdata[PWMT_MODE_OE];
                    next_st.clock_select_field = reg_wdata[PWMT_MODE_CKS_LO +: PWMT_MODE_CKS_W];
                    if (reg_wdata[PWMT_MODE_RUN] && !st.timer_run_bit) begin
                        next_st.count = 8'h00; // RULE4
                        next_st.active = 1'b0; // RULE1
                        next_st.prescale = 8'h00;
                    end
                end
                PWMT_OFS_PERIOD: begin
                    // Taken at once; a write while running ends the cycle at the new value, or only after a wrap past 255 if the count is above it
                    next_st.period_compare = reg_wdata; // RULE2
                end
                PWMT_OFS_DUTY: begin
                    next_st.duty_compare = reg_wdata; // RULE3
                    if (st.timer_run_bit) begin
                        next_st.duty_wait = PWMT_DUTY_DELAY; // RULE13
                    end else begin
                        next_st.duty_compare_alias = reg_wdata;
                        next_st.duty_wait = 2'h0;
                    end
                end
                PWMT_OFS_MASK: begin
                    next_st.mask = reg_wdata[PWMT_ST_PERIOD];
                end
                default: begin
                end
            endcase
        end
        // Pin level; active low select inverts the waveform
        if (!next_st.output_enable_bit) begin
            next_st.pin = 1'b0; // RULE6 RULE7 RULE9
        end else begin
            next_st.pin = next_st.active ^ next_st.active_level_select; // RULE8
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Everything not named below starts at zero
            st <= '0;
            // Mode register
            st.timer_run_bit <= PWMT_RST_MODE[PWMT_MODE_RUN];
            st.active_level_select <= PWMT_RST_MODE[PWMT_MODE_LEVEL];
            st.output_enable_bit <= PWMT_RST_MODE[PWMT_MODE_OE];
            st.clock_select_field <= PWMT_RST_MODE[PWMT_MODE_CKS_LO +: PWMT_MODE_CKS_W];
            // Compare registers and mask
            st.period_compare <= PWMT_RST_PERIOD;
            st.duty_compare <= PWMT_RST_DUTY;
            st.duty_compare_alias <= PWMT_RST_DUTY;
            st.mask <= PWMT_RST_MASK[PWMT_ST_PERIOD];
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign pwm_output_pin = st.pin;
    assign period_interrupt = st.status & ~st.mask;

endmodule // pwmt_top

// >>> tb/pwmt_props.sv
// Port checker for the PWM timer channel
`timescale 1ns/1ps
module pwmt_props
    import pwmt_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [PWMT_AW-1:0] reg_addr,
    input wire logic [PWMT_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [PWMT_DW-1:0] reg_rdata,
    // Timer outputs
    input wire logic pwm_output_pin,
    input wire logic period_interrupt
);
    logic [7:0] md;
    logic mk;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            md <= PWMT_RST_MODE;
            mk <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == PWMT_OFS_MODE) md <= reg_wdata & 8'h77;
            if (reg_addr == PWMT_OFS_MASK) mk <= reg_wdata[0];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
    AST_RD_MODE: assert property (reg_rd && reg_addr == PWMT_OFS_MODE |=> reg_rdata == md) else $error("mode readback");
    AST_RD_HOLE: assert property (reg_rd && reg_addr > PWMT_OFS_COUNT |=> reg_rdata == 8'h00) else $error("unmapped read");
    AST_OE_LOW: assert property (!md[2] && $stable(md) |-> !pwm_output_pin) else $error("pin not low");
    AST_STOP: assert property (!md[0] && $stable(md) |-> pwm_output_pin == (md[2] & md[1])) else $error("stop level");
    AST_START: assert property ($rose(md[0]) && md[2] |-> (pwm_output_pin == md[1]) [*2]) else $error("start level");
    AST_IRQ_RUN: assert property ($rose(period_interrupt) |-> $past(md[0])) else $error("irq while stopped");
    AST_IRQ_ACT: assert property ($rose(period_interrupt) && md[2] |-> pwm_output_pin != md[1]) else $error("match level");
    AST_IRQ_MASK: assert property (mk && $stable(mk) |-> !period_interrupt) else $error("masked irq");
    AST_CLR: assert property (reg_rd && reg_addr == PWMT_OFS_STATUS && period_interrupt |=> reg_rdata[0] && !period_interrupt)
        else $error("status read clear");
endmodule // pwmt_props
bind pwmt_top pwmt_props pwmt_props_inst (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pwm_output_pin, .period_interrupt);

// >>> tb/pwm_timer_8bit_tb.sv
// Self-checking bench for the PWM timer channel
`timescale 1ns/1ps
module pwm_timer_8bit_tb;
    import pwmt_pkg::*;
    logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, lv, mk;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic pwm_output_pin, period_interrupt;
    int err_total = 0, n_checks = 0, seed = 35657, p, d, s, n;
    pwmt_top pwmt_top_inst (.sys_clk, .rst_n, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .pwm_output_pin, .period_interrupt);
    initial forever #10 sys_clk = ~sys_clk;
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk("rdata", e, reg_rdata);
    endtask
    // Count cycles until the active-relative pin level equals v
    task automatic wt(logic v);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1 n++;
        end while ((pwm_output_pin ^ lv) !== v && n < 999);
        if (n >= 999) chk("wait limit", 0, 1);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #200000 err_total++;
        end_sim;
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(PWMT_OFS_MODE, PWMT_RST_MODE);
        rd(PWMT_OFS_PERIOD, PWMT_RST_PERIOD);
        rd(PWMT_OFS_DUTY, PWMT_RST_DUTY);
        rd(PWMT_OFS_MASK, PWMT_RST_MASK);
        rd(8'h20, 8'h00);
        for (int i = 0; i < 6; i++) begin
            p = 8 + {$random(seed)} % 32;
            d = 2 + {$random(seed)} % (p - 2);
            s = i % 2;
            {lv, mk} = 2'($random(seed));
            wr(PWMT_OFS_PERIOD, 8'(p));
            wr(PWMT_OFS_DUTY, 8'(d));
            wr(PWMT_OFS_MASK, {7'h00, mk});
            wr(PWMT_OFS_MODE, {1'b0, 3'(s), 2'h1, lv, 1'b1});
            wt(1);
            if (s == 0) chk("first match", p + 1, n);
            wt(0);
            chk("active width", (d + 1) << s, n);
            wt(1);
            chk("inactive width", (p - d) << s, n);
            chk("irq", !mk, period_interrupt);
            // Duty written just after a match reaches the compare three ticks later
            if (s == 0) begin
                wr(PWMT_OFS_DUTY, 8'(p - 1));
                wt(0);
                chk("duty delay", (d <= 4) ? d + 1 : p, n + 2);
            end
            wr(PWMT_OFS_MODE, {6'h01, lv, 1'b0});
            rd(PWMT_OFS_STATUS, 8'h01);
            rd(PWMT_OFS_COUNT, 8'h00);
            chk("idle pin", lv, pwm_output_pin);
        end
        wr(PWMT_OFS_MODE, 8'h02);
        rd(PWMT_OFS_MODE, 8'h02);
        chk("disabled pin", 0, pwm_output_pin);
        end_sim;
    end
endmodule // pwm_timer_8bit_tb
